// >>> hw/jtag_cfg_pkg.sv
// constants, states and carriers shared by the test-port configuration loader
// Contract
// - five tck cycles with tms high put the tap in test-logic-reset.
// - opcode shifted lsb first, last bit on exit, decodes as config input.
// - under config input, every bit shifted in shift-dr is config data.
// - data register fills from its msb end next to tdi, moving toward lsb.
// - startup instruction loaded via shift-ir prepares device start-up.
// - startup advances on tck cycles in idle, at least twelve of them.
// - three tms-high cycles to test-logic-reset leave the device operational.
// - startup runs from tck only when the bitstream selects the tck source.
// - configured device accepts new load after program-clear or shutdown.
// - instruction register is six bits and captures device status.
// - configuration data register is sixty-four bits long.
// - tdo is driven only in shift-dr and shift-ir.
package jtag_cfg_pkg;

	localparam int IR_BITS = 6;
	localparam int DR_BITS = 64;
	localparam logic [5:0] INSTR_CFG_IN = 6'h05;
	localparam logic [5:0] INSTR_STARTUP = 6'h0c;
	localparam logic [5:0] INSTR_BYPASS = 6'h3f;
	localparam logic [5:0] IR_RESET_VALUE = 6'h3f;
	localparam logic [1:0] IR_CAPTURE_TAIL = 2'h1;
	localparam logic [3:0] STARTUP_CYCLES = 4'hc;
	// top byte of a word that carries the startup clock selection in bit 0
	localparam logic [7:0] STARTUP_SEL_KEY = 8'ha5;
	localparam int STARTUP_SEL_MSB = 63;
	localparam int STARTUP_SEL_LSB = 56;
	localparam logic [2:0] MODE_TEST_PORT = 3'h5;
	localparam int RESET_TMS_CYCLES = 5;
	// clk edges before the synchronised mode pins can be trusted
	localparam logic [1:0] MODE_SETTLE_CYCLES = 2'h2;

	typedef enum logic [3:0] {
		TEST_LOGIC_RESET, RUN_IDLE,
		SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR,
		UPDATE_DR,
		SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR,
		UPDATE_IR
	} tap_state_t;

	typedef struct packed {
		logic [63:0] data;
		logic startup_tck;
	} cfg_word_t;

	typedef struct packed {
		logic high;
		logic mid;
		logic low;
	} mode_pins_t;

endpackage : jtag_cfg_pkg

// >>> hw/jtag_config_loader.sv
// test access port with configuration-input and startup instructions
`timescale 1ns/1ns
module jtag_config_loader
	import jtag_cfg_pkg::*;
#(
	parameter int IR_WIDTH = IR_BITS,
	parameter int DR_WIDTH = DR_BITS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe,
	input wire logic program_clear_input,
	input wire mode_pins_t mode_pins,
	output cfg_word_t cfg_word,
	output logic cfg_word_valid,
	output logic startup_done,
	output logic operational,
	output logic test_port_mode
);
	// the shift paths are written for the documented widths only
	if (IR_WIDTH != IR_BITS) begin : g_ir_width
		$error("instruction register must be 6 bits");
	end
	if (DR_WIDTH != DR_BITS) begin : g_dr_width
		$error("data register must be 64 bits");
	end

	// ----------------------------------------------------------------
	// tap controller, tck domain
	// ----------------------------------------------------------------
	function automatic tap_state_t tap_next(tap_state_t s, logic m);
		unique case (s)
			TEST_LOGIC_RESET: tap_next = m ? TEST_LOGIC_RESET : RUN_IDLE;
			RUN_IDLE: tap_next = m ? SELECT_DR : RUN_IDLE;
			SELECT_DR: tap_next = m ? SELECT_IR : CAPTURE_DR;
			CAPTURE_DR: tap_next = m ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR: tap_next = m ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR: tap_next = m ? UPDATE_DR : PAUSE_DR;
			PAUSE_DR: tap_next = m ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR: tap_next = m ? UPDATE_DR : SHIFT_DR;
			UPDATE_DR: tap_next = m ? SELECT_DR : RUN_IDLE;
			SELECT_IR: tap_next = m ? TEST_LOGIC_RESET : CAPTURE_IR;
			CAPTURE_IR: tap_next = m ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR: tap_next = m ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR: tap_next = m ? UPDATE_IR : PAUSE_IR;
			PAUSE_IR: tap_next = m ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR: tap_next = m ? UPDATE_IR : SHIFT_IR;
			UPDATE_IR: tap_next = m ? SELECT_DR : RUN_IDLE;
		endcase
	endfunction : tap_next

	tap_state_t tap_state, next_tap_state;
	logic [5:0] ir, next_ir;
	logic [5:0] ir_shift, next_ir_shift;
	logic [63:0] dr_shift, next_dr_shift;
	logic bypass, next_bypass;
	cfg_word_t word_hold, next_word_hold;
	logic word_toggle, next_word_toggle;
	logic configured, next_configured;
	logic startup_src_tck, next_startup_src_tck;
	logic [3:0] startup_count, next_startup_count;
	logic done_tck, next_done_tck;
	logic oper_tck, next_oper_tck;
	logic clear_tck;
	logic next_tdo, next_tdo_oe;

	// program-clear is a pin, so it reaches the tck logic synchronised;
	// tck must run for it to take effect there
	level_sync #(.WIDTH(1)) u_clear_sync (
		.clk(tck),
		.rst(rst),
		.d(program_clear_input),
		.q(clear_tck)
	);

	always_comb begin
		next_tap_state = tap_next(tap_state, tms);
		next_ir = ir;
		next_ir_shift = ir_shift;
		next_dr_shift = dr_shift;
		next_bypass = bypass;
		next_word_hold = word_hold;
		next_word_toggle = word_toggle;
		next_configured = configured;
		next_startup_src_tck = startup_src_tck;
		next_startup_count = startup_count;
		next_done_tck = done_tck;
		next_oper_tck = oper_tck;
		unique case (tap_state)
			TEST_LOGIC_RESET: next_ir = IR_RESET_VALUE;
			CAPTURE_IR: next_ir_shift = {done_tck, configured, 2'h0,
				IR_CAPTURE_TAIL};
			SHIFT_IR: next_ir_shift = {tdi, ir_shift[5:1]};
			UPDATE_IR: next_ir = ir_shift;
			CAPTURE_DR: next_bypass = 1'b0;
			SHIFT_DR: begin
				if (ir == INSTR_CFG_IN)
					next_dr_shift = {tdi, dr_shift[63:1]};
				else
					next_bypass = tdi;
			end
			UPDATE_DR: begin
				if (ir == INSTR_CFG_IN) begin
					next_configured = 1'b1;
					next_word_hold.data = dr_shift;
					next_word_hold.startup_tck = startup_src_tck;
					if (dr_shift[STARTUP_SEL_MSB:STARTUP_SEL_LSB]
						== STARTUP_SEL_KEY) begin
						next_startup_src_tck = dr_shift[0];
						next_word_hold.startup_tck = dr_shift[0];
					end
					next_word_toggle = ~word_toggle;
					// a fresh load restarts the startup sequence
					next_startup_count = 4'h0;
					next_done_tck = 1'b0;
					next_oper_tck = 1'b0;
				end
			end
			RUN_IDLE: begin
				if (ir == INSTR_STARTUP && configured && startup_src_tck
					&& !done_tck) begin
					next_startup_count = startup_count + 4'h1;
					if (startup_count + 4'h1 >= STARTUP_CYCLES)
						next_done_tck = 1'b1;
				end
			end
			default: begin
			end
		endcase
		// operational from the edge that enters test-logic-reset
		if (next_tap_state == TEST_LOGIC_RESET && done_tck)
			next_oper_tck = 1'b1;
		if (clear_tck) begin
			next_configured = 1'b0;
			next_startup_src_tck = 1'b0;
			next_startup_count = 4'h0;
			next_done_tck = 1'b0;
			next_oper_tck = 1'b0;
		end
		// tdo only in the two shift states; others leave the wire free
		next_tdo_oe = (tap_state == SHIFT_DR)
			|| (tap_state == SHIFT_IR);
		if (tap_state == SHIFT_IR)
			next_tdo = ir_shift[0];
		else if (ir == INSTR_CFG_IN)
			next_tdo = dr_shift[0];
		else
			next_tdo = bypass;
	end

	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			tap_state <= TEST_LOGIC_RESET;
			ir <= IR_RESET_VALUE;
			ir_shift <= '0;
			dr_shift <= '0;
			bypass <= 1'b0;
			word_hold <= '0;
			word_toggle <= 1'b0;
			configured <= 1'b0;
			startup_src_tck <= 1'b0;
			startup_count <= 4'h0;
			done_tck <= 1'b0;
			oper_tck <= 1'b0;
		end else begin
			tap_state <= next_tap_state;
			ir <= next_ir;
			ir_shift <= next_ir_shift;
			dr_shift <= next_dr_shift;
			bypass <= next_bypass;
			word_hold <= next_word_hold;
			word_toggle <= next_word_toggle;
			configured <= next_configured;
			startup_src_tck <= next_startup_src_tck;
			startup_count <= next_startup_count;
			done_tck <= next_done_tck;
			oper_tck <= next_oper_tck;
		end
	end

	// tdo moves on the falling edge, giving the master half a cycle
	always_ff @(negedge tck or posedge rst) begin
		if (rst) begin
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tdo <= next_tdo;
			tdo_oe <= next_tdo_oe;
		end
	end

	// ----------------------------------------------------------------
	// system side, clk domain
	// ----------------------------------------------------------------
	logic [5:0] sync_out;
	logic toggle_seen, next_toggle_seen;
	cfg_word_t next_cfg_word;
	logic next_cfg_word_valid;
	logic mode_taken, next_mode_taken;
	logic [1:0] mode_wait, next_mode_wait;
	logic next_test_port_mode;

	// word_hold is stable for at least 64 tck cycles after each toggle when all 64 bits are shifted before update-dr,
	// so it is safe to sample once the synchronised toggle moves
	level_sync #(.WIDTH(6)) u_sys_sync (
		.clk(clk),
		.rst(rst),
		.d({word_toggle, done_tck, oper_tck, mode_pins}),
		.q(sync_out)
	);

	always_comb begin
		next_toggle_seen = sync_out[5];
		next_cfg_word = cfg_word;
		next_cfg_word_valid = sync_out[5] != toggle_seen;
		if (next_cfg_word_valid) next_cfg_word = word_hold;
		// the pins are only valid once both sync stages have filled
		next_mode_wait = mode_wait;
		if (mode_wait != MODE_SETTLE_CYCLES)
			next_mode_wait = mode_wait + 2'h1;
		next_mode_taken = mode_taken || (mode_wait == MODE_SETTLE_CYCLES);
		next_test_port_mode = test_port_mode;
		if (!mode_taken && mode_wait == MODE_SETTLE_CYCLES)
			next_test_port_mode = sync_out[2:0] == MODE_TEST_PORT;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			toggle_seen <= 1'b0;
			cfg_word <= '0;
			cfg_word_valid <= 1'b0;
			startup_done <= 1'b0;
			operational <= 1'b0;
			mode_taken <= 1'b0;
			mode_wait <= 2'h0;
			test_port_mode <= 1'b0;
		end else begin
			toggle_seen <= next_toggle_seen;
			cfg_word <= next_cfg_word;
			cfg_word_valid <= next_cfg_word_valid;
			startup_done <= sync_out[4];
			operational <= sync_out[3];
			mode_taken <= next_mode_taken;
			mode_wait <= next_mode_wait;
			test_port_mode <= next_test_port_mode;
		end
	end
endmodule : jtag_config_loader

// >>> hw/level_sync.sv
// two-flop synchroniser for a bundle of levels
`timescale 1ns/1ns
module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_q;

	if (WIDTH < 1) begin : g_bad_width
		$error("level_sync width must be positive");
	end

	// first stage feeds only the second stage
	always_comb begin
		next_meta = d;
		next_q = meta;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= next_meta;
			q <= next_q;
		end
	end
endmodule : level_sync

// >>> verification/jtag_cfg_asserts.sv
// concurrent checks on the loader's ports
`timescale 1ns/1ns
module jtag_cfg_checker
	import jtag_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdo_oe,
	input wire logic program_clear_input,
	input wire cfg_word_t cfg_word,
	input wire logic cfg_word_valid,
	input wire logic startup_done,
	input wire logic operational
);
	// ----
	// link side
	// ----
	oe_release_a: assert property (@(posedge tck) disable iff (rst)
		tms |=> !tdo_oe) else $error("tdo driven after tms high");
	oe_entry_a: assert property (@(posedge tck) disable iff (rst)
		$rose(tdo_oe) |-> !$past(tms))
		else $error("shift entered without tms low");
	// ----
	// system side
	// ----
	valid_pulse_a: assert property (@(posedge clk) disable iff (rst)
		cfg_word_valid |=> !cfg_word_valid) else $error("valid too long");
	word_hold_a: assert property (@(posedge clk) disable iff (rst)
		!cfg_word_valid |-> $stable(cfg_word)) else $error("word moved");
	sel_field_a: assert property (@(posedge clk) disable iff (rst)
		cfg_word_valid && cfg_word.data[63:56] == STARTUP_SEL_KEY
		|-> cfg_word.startup_tck == cfg_word.data[0])
		else $error("clock source not taken");
	done_source_a: assert property (@(posedge clk) disable iff (rst)
		$rose(startup_done) |-> cfg_word.startup_tck)
		else $error("startup without tck source");
	oper_done_a: assert property (@(posedge clk) disable iff (rst)
		$rose(operational) |-> startup_done)
		else $error("operational before startup");
	clear_wins_a: assert property (@(posedge clk) disable iff (rst)
		program_clear_input [*8] |-> !startup_done && !operational)
		else $error("clear did not take");
endmodule : jtag_cfg_checker

// >>> verification/jtag_master_model.sv
// behavioural test-port master driving the loader's link pins
`timescale 1ns/1ns
module jtag_master_model (
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	// tck parks low between frames, like a real probe
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// pins change while tck is low and hold past the rise
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#16;
		tck = 1'b1;
		o = tdo;
		#16;
		tck = 1'b0;
	endtask : step
	// don't-care tdi toggles so a stale level never looks valid
	task automatic tick(input logic m);
		logic o;
		step(m, ~tdi, o);
	endtask : tick
	task automatic reset5();
		repeat (5) tick(1'b1);
	endtask : reset5
	task automatic to_shift(input logic ir);
		tick(1'b1);
		if (ir) tick(1'b1);
		tick(1'b0);
		tick(1'b0);
	endtask : to_shift
	task automatic shift(input logic [63:0] v, input int n, input logic msb,
		output logic [63:0] q);
		q = 64'h0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, v[msb ? n - 1 - i : i], q[i]);
		end
		tick(1'b1);
	endtask : shift
endmodule : jtag_master_model

// >>> verification/tb_top.sv
// self-checking bench for the test-port configuration loader
`timescale 1ns/1ns
module tb_top
	import jtag_cfg_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic program_clear_input = 1'b0;
	mode_pins_t mode_pins = MODE_TEST_PORT;
	logic tck, tms, tdi, tdo, tdo_oe, cfg_word_valid, startup_done;
	logic operational, test_port_mode;
	cfg_word_t cfg_word;
	logic [63:0] q;
	int fail_count = 0;
	int check_count = 0;
	int cycles = 0;
	int word_count = 0;
	always #25 clk = ~clk;
	// valid stands one clk, so the falling edge always sees it
	always @(negedge clk) begin
		if (cfg_word_valid === 1'b1) word_count++;
	end
	jtag_config_loader dut_u (.clk(clk), .rst(rst), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .mode_pins(mode_pins),
		.program_clear_input(program_clear_input), .cfg_word(cfg_word),
		.cfg_word_valid(cfg_word_valid), .startup_done(startup_done),
		.operational(operational), .test_port_mode(test_port_mode));
	jtag_master_model master_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	// ----
	// helpers
	// ----
	task automatic check(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test
	// bitstream msb lands in register bit 0 after all 64 shifts
	function automatic logic [63:0] stream_of(input logic [63:0] w);
		for (int i = 0; i < 64; i++) begin
			stream_of[63 - i] = w[i];
		end
	endfunction : stream_of
	task automatic load(input logic [63:0] w, input logic sel);
		int n;
		master_u.tick(1'b0);
		master_u.to_shift(1'b1);
		master_u.shift({58'h0, INSTR_CFG_IN}, 6, 1'b0, q);
		check(q[3:0] === 4'h1, "ir capture");
		master_u.to_shift(1'b0);
		master_u.shift(stream_of(w), 64, 1'b1, q);
		// update-dr only acts on the next tck rise, on the way to idle
		master_u.tick(1'b0);
		n = 0;
		while (cfg_word_valid !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		check(cfg_word_valid === 1'b1, "no word");
		check(cfg_word.data === w, "word data");
		check(cfg_word.startup_tck === sel, "clock source");
	endtask : load
	task automatic run_start(input int n);
		master_u.reset5();
		master_u.tick(1'b0);
		master_u.to_shift(1'b1);
		master_u.shift({58'h0, INSTR_STARTUP}, 6, 1'b0, q);
		repeat (n) master_u.tick(1'b0);
		repeat (10) @(negedge clk);
	endtask : run_start
	// ----
	// scenarios
	// ----
	task automatic t_bypass();
		int seen;
		seen = word_count;
		master_u.tick(1'b0);
		master_u.to_shift(1'b1);
		master_u.shift({58'h0, INSTR_BYPASS}, 6, 1'b0, q);
		check(q[3:0] === 4'h1, "bypass capture");
		master_u.to_shift(1'b0);
		master_u.shift(64'h0000_0000_0000_00b5, 8, 1'b0, q);
		check(q[7:0] === 8'h6a, "bypass echo");
		master_u.tick(1'b0);
		repeat (10) @(negedge clk);
		check(word_count == seen, "bypass word");
		master_u.reset5();
	endtask : t_bypass
	task automatic t_mode();
		@(negedge clk);
		rst = 1'b1;
		mode_pins = 3'h1;
		master_u.tick(1'b1);
		@(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		check(test_port_mode === 1'b0, "mode off");
		check(cfg_word === '0 && !startup_done && !operational,
			"reset values");
		master_u.reset5();
	endtask : t_mode
	task automatic t_load();
		check(test_port_mode === 1'b1, "mode");
		load(64'ha55a_3c96_0f1e_2d4b, 1'b1);
	endtask : t_load
	task automatic t_start();
		// the first idle tick only applies update-ir, so 12 give 11 counts
		run_start(12);
		check(startup_done === 1'b0, "early done");
		master_u.tick(1'b0);
		repeat (10) @(negedge clk);
		check(startup_done === 1'b1, "no done");
		repeat (3) master_u.tick(1'b1);
		repeat (10) @(negedge clk);
		check(operational === 1'b1, "not operational");
	endtask : t_start
	task automatic t_clear();
		program_clear_input = 1'b1;
		repeat (4) master_u.tick(1'b1);
		repeat (10) @(negedge clk);
		check(!startup_done && !operational, "clear");
		program_clear_input = 1'b0;
		load(64'ha512_3456_789a_bcde, 1'b0);
		run_start(13);
		check(startup_done === 1'b0, "startup off source");
	endtask : t_clear
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			check(1'b0, "timeout");
			end_of_test();
		end
	end
	initial begin
		@(negedge clk);
		master_u.tick(1'b1);
		@(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		master_u.reset5();
		t_bypass();
		t_load();
		t_start();
		@(negedge clk);
		t_clear();
		t_mode();
		end_of_test();
	end
endmodule : tb_top
bind jtag_config_loader jtag_cfg_checker chk_u (.clk(clk), .rst(rst),
	.tck(tck), .tms(tms), .tdo_oe(tdo_oe),
	.program_clear_input(program_clear_input), .cfg_word(cfg_word),
	.cfg_word_valid(cfg_word_valid), .startup_done(startup_done),
	.operational(operational));
